// *** core/mgmt_status_timing.sv ***
// Our own choices: the AHB-Lite interface to the registers and the register offsets.
`default_nettype none

module mgmt_status_timing #(
    parameter int US_PER_MS = 1000,
    parameter int INIT_MS = 1999
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire mgmt_pkg::pins_s modPins,
    input wire logic module_reset_n,
    output mgmt_pkg::lane_out_s laneOut,
    output logic lowPower,
    output logic intN,
    output logic irq
);
    import mgmt_pkg::*;

    localparam int PIN_W = $bits(pins_s) + 1;

    // ==========================================================
    // Elaboration checks
    if (INIT_MS < 1 || INIT_MS >= T_DATA_MS) begin : g_bad_init
        $error("INIT_MS must lie between 1 and the ready bound");
    end
    if (US_PER_MS < 2 || US_PER_MS > US_PER_MS_DOC) begin : g_bad_us
        $error("US_PER_MS out of range");
    end
    if (SYNC_DEPTH + 4 > RXSQ_CYC) begin : g_bad_sync
        $error("Synchroniser too slow for receive squelch bound");
    end

    // ==========================================================
    // Pin synchronisers
    logic [PIN_W-1:0] pinRaw;
    logic [PIN_W-1:0] sync1_ff;
    logic [PIN_W-1:0] sync2_ff;
    logic [PIN_W-1:0] sync3_ff;
    logic [PIN_W-1:0] stable_ff;
    logic [PIN_W-1:0] nxt_stable;
    localparam logic [PIN_W-1:0] PIN_RST = {1'b1, {(PIN_W-1){1'b0}}};

    assign pinRaw = {module_reset_n, modPins};

    // A pin change counts only once stage two and three agree
    genvar gi;
    for (gi = 0; gi < PIN_W; gi++) begin : g_sync
        assign nxt_stable[gi] = (sync2_ff[gi] == sync3_ff[gi]) ? sync3_ff[gi] : stable_ff[gi];
    end

    // Three-stage capture, first stage feeds only the second
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sync1_ff <= PIN_RST;
            sync2_ff <= PIN_RST;
            sync3_ff <= PIN_RST;
            stable_ff <= PIN_RST;
        end else begin
            sync1_ff <= pinRaw;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            stable_ff <= nxt_stable;
        end
    end

    pins_s pinNow;
    logic pinResetN;
    logic softRst;
    assign pinNow = stable_ff[PIN_W-2:0];
    assign pinResetN = stable_ff[PIN_W-1];
    // Reset pin low holds the module logic; the bus itself keeps answering
    assign softRst = rst | ~pinResetN;

    // ==========================================================
    // Time base: microsecond and millisecond enables
    logic [4:0] usDiv_ff;
    logic [9:0] usCnt_ff;
    logic usTick;
    logic msTick;
    localparam logic [4:0] US_LAST = 5'(CYC_PER_US - 1);
    localparam logic [9:0] MS_LAST = 10'(US_PER_MS - 1);

    assign usTick = (usDiv_ff == US_LAST);
    assign msTick = usTick && (usCnt_ff == MS_LAST);

    // Free-running dividers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            usDiv_ff <= 5'h00;
            usCnt_ff <= 10'h000;
        end else begin
            usDiv_ff <= usTick ? 5'h00 : usDiv_ff + 5'h01;
            if (usTick) begin
                usCnt_ff <= (usCnt_ff == MS_LAST) ? 10'h000 : usCnt_ff + 10'h001;
            end
        end
    end

    // ==========================================================
    // Readiness after power or reset pin
    logic [10:0] initCnt_ff;
    mode_e mode_ff;
    mode_e nxt_mode;
    logic readyEvt;
    ctrl_s ctrl_ff;
    localparam logic [10:0] INIT_LAST = 11'(INIT_MS);

    // Ready event fires once, on leaving initialisation
    assign readyEvt = (mode_ff == ST_INIT) && msTick && (initCnt_ff == INIT_LAST);

    // Mode sequencing; low power is left at once when the bit drops
    always_comb begin
        nxt_mode = mode_ff;
        case (mode_ff)
            ST_INIT: begin
                if (readyEvt) begin
                    nxt_mode = ctrl_ff.pwrDown ? ST_LOWPWR : ST_RUN;
                end
            end
            ST_RUN: begin
                if (ctrl_ff.pwrDown) begin
                    nxt_mode = ST_LOWPWR;
                end
            end
            ST_LOWPWR: begin
                if (!ctrl_ff.pwrDown) begin
                    nxt_mode = ST_RUN;
                end
            end
            default: begin
                nxt_mode = ST_INIT;
            end
        endcase
    end

    // Init counter restarts on every reset-pin release
    always_ff @(posedge ref_clk) begin
        if (softRst) begin
            mode_ff <= ST_INIT;
            initCnt_ff <= 11'h000;
        end else begin
            mode_ff <= nxt_mode;
            if (mode_ff == ST_INIT && msTick) begin
                initCnt_ff <= initCnt_ff + 11'h001;
            end
        end
    end

    // ==========================================================
    // Bus address phase capture
    logic addrTake;
    logic [OFF_W-1:0] addrOff;
    logic wrPend_ff;
    logic [OFF_W-1:0] wrOff_ff;
    logic rdFlags;

    assign addrTake = hsel && hready && htrans[1];
    assign addrOff = haddr[OFF_W-1:0];
    // Read of the flag word clears it at the address edge
    assign rdFlags = addrTake && !hwrite && (addrOff == OFF_FLAGS);

    // Write data follows one cycle later, so hold the target
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wrPend_ff <= 1'b0;
            wrOff_ff <= 8'h00;
        end else begin
            wrPend_ff <= addrTake && hwrite;
            wrOff_ff <= addrOff;
        end
    end

    // ==========================================================
    // Write decode
    logic wrFlags;
    logic wrMask;
    logic wrCtrl;
    assign wrFlags = wrPend_ff && (wrOff_ff == OFF_FLAGS);
    assign wrMask = wrPend_ff && (wrOff_ff == OFF_MASK);
    assign wrCtrl = wrPend_ff && (wrOff_ff == OFF_CTRL);

    // ==========================================================
    // Flags, mask, control
    flags_s flags_ff;
    flags_s mask_ff;
    pins_s prevPins_ff;
    logic [FLAG_W-1:0] flagSet;
    logic [FLAG_W-1:0] flagClr;

    // Entering a condition raises its flag
    assign flagSet[FLG_RXLOS_LSB +: LANES] = pinNow.rxLos & ~prevPins_ff.rxLos;
    assign flagSet[FLG_TXFLT_LSB +: LANES] = pinNow.txFlt & ~prevPins_ff.txFlt;
    assign flagSet[FLG_OTHER_LSB +: LANES] = pinNow.other & ~prevPins_ff.other;
    assign flagSet[FLG_READY_BIT] = readyEvt;
    // Clear on read, or write one to clear
    assign flagClr = rdFlags ? {FLAG_W{1'b1}} : (wrFlags ? hwdata[FLAG_W-1:0] : {FLAG_W{1'b0}});

    // A flag set in the cycle it is cleared survives
    always_ff @(posedge ref_clk) begin
        if (softRst) begin
            flags_ff <= FLAGS_RST;
            prevPins_ff <= '0;
        end else begin
            flags_ff <= (flags_ff & ~flagClr) | flagSet;
            prevPins_ff <= pinNow;
        end
    end

    // Mask and lane control registers
    always_ff @(posedge ref_clk) begin
        if (softRst) begin
            mask_ff <= MASK_RST;
            ctrl_ff <= CTRL_RST;
        end else begin
            if (wrMask) begin
                mask_ff <= hwdata[FLAG_W-1:0];
            end
            if (wrCtrl) begin
                ctrl_ff <= hwdata[CTRL_W-1:0];
            end
        end
    end

    // ==========================================================
    // Interrupt output
    logic irqNow;
    logic irq_ff;
    // Level stays up while any unmasked flag remains
    assign irqNow = |(flags_ff & ~mask_ff);

    // One register stage; release follows a clear within two cycles
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= irqNow;
        end
    end

    assign irq = irq_ff;
    assign intN = ~irq_ff;

    // ==========================================================
    // Lane output enables
    logic running;
    logic [LANES-1:0] rxSquelch;
    logic [LANES-1:0] txSquelch;
    logic [LANES-1:0] nxt_txOn;
    logic [LANES-1:0] nxt_rxOn;
    logic [LANES-1:0] txOn_ff;
    logic [LANES-1:0] rxOn_ff;
    logic lowPower_ff;

    assign running = (mode_ff == ST_RUN);
    // Squelch-disable overrides both automatic squelches
    assign rxSquelch = pinNow.rxLos & {LANES{~ctrl_ff.sqDis}};
    assign txSquelch = pinNow.txLost & {LANES{~ctrl_ff.sqDis}};
    assign nxt_txOn = {LANES{running}} & ~ctrl_ff.txDis & ~txSquelch;
    assign nxt_rxOn = {LANES{running}} & ~ctrl_ff.rxDis & ~rxSquelch;

    // Registered enables; a few cycles is far inside every bound
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            txOn_ff <= '0;
            rxOn_ff <= '0;
            lowPower_ff <= 1'b0;
        end else begin
            txOn_ff <= nxt_txOn;
            rxOn_ff <= nxt_rxOn;
            lowPower_ff <= (mode_ff == ST_LOWPWR);
        end
    end

    assign laneOut = '{rxOn: rxOn_ff, txOn: txOn_ff};
    assign lowPower = lowPower_ff;

    // ==========================================================
    // Read data
    logic [31:0] statusWord;
    logic [31:0] rdMux;
    logic [31:0] hrdata_ff;

    // Not-ready stays high until initialisation ends
    always_comb begin
        statusWord = 32'h0000_0000;
        statusWord[ST_RXLOS_LSB +: LANES] = pinNow.rxLos;
        statusWord[ST_TXLOST_LSB +: LANES] = pinNow.txLost;
        statusWord[ST_TXFLT_LSB +: LANES] = pinNow.txFlt;
        statusWord[ST_LOWPWR_BIT] = lowPower_ff;
        statusWord[ST_NOTREADY_BIT] = (mode_ff == ST_INIT);
    end

    // Unmapped offsets read as zero
    always_comb begin
        if (addrOff == OFF_FLAGS) begin
            rdMux = {{(32-FLAG_W){1'b0}}, flags_ff};
        end else if (addrOff == OFF_MASK) begin
            rdMux = {{(32-FLAG_W){1'b0}}, mask_ff};
        end else if (addrOff == OFF_CTRL) begin
            rdMux = {{(32-CTRL_W){1'b0}}, ctrl_ff};
        end else if (addrOff == OFF_STATUS) begin
            rdMux = statusWord;
        end else begin
            rdMux = 32'h0000_0000;
        end
    end

    // Data is caught at the address edge, so the slave never waits
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            hrdata_ff <= 32'h0000_0000;
        end else if (addrTake && !hwrite) begin
            hrdata_ff <= rdMux;
        end
    end

    assign hrdata = hrdata_ff;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

endmodule : mgmt_status_timing

`default_nettype wire

// *** common/mgmt_pkg.sv ***
`default_nettype none

package mgmt_pkg;

    // ==========================================================
    // Geometry
    localparam int LANES = 4;
    localparam int OFF_W = 8;

    // ==========================================================
    // Register byte offsets
    localparam logic [OFF_W-1:0] OFF_FLAGS = 8'h00;
    localparam logic [OFF_W-1:0] OFF_MASK = 8'h04;
    localparam logic [OFF_W-1:0] OFF_CTRL = 8'h08;
    localparam logic [OFF_W-1:0] OFF_STATUS = 8'h0C;

    // ==========================================================
    // Field layouts (flags and mask share one layout)
    localparam int FLAG_W = 13;
    localparam int FLG_RXLOS_LSB = 0;
    localparam int FLG_TXFLT_LSB = 4;
    localparam int FLG_OTHER_LSB = 8;
    localparam int FLG_READY_BIT = 12;
    localparam int CTRL_W = 10;
    localparam int CTL_TXDIS_LSB = 0;
    localparam int CTL_RXDIS_LSB = 4;
    localparam int CTL_SQDIS_BIT = 8;
    localparam int CTL_PDOWN_BIT = 9;
    localparam int ST_RXLOS_LSB = 0;
    localparam int ST_TXLOST_LSB = 4;
    localparam int ST_TXFLT_LSB = 8;
    localparam int ST_LOWPWR_BIT = 12;
    localparam int ST_NOTREADY_BIT = 16;

    // ==========================================================
    // Reset values
    localparam logic [FLAG_W-1:0] FLAGS_RST = 13'h0000;
    localparam logic [FLAG_W-1:0] MASK_RST = 13'h0000;
    localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;

    // ==========================================================
    // Timing
    localparam int CLK_HZ = 25000000;
    localparam int CYC_PER_US = CLK_HZ / 1000000;
    localparam int US_PER_MS_DOC = 1000;
    localparam int T_DATA_MS = 2000;
    localparam int T_RXSQ_US = 80;
    localparam int RXSQ_CYC = T_RXSQ_US * CYC_PER_US;
    localparam int SYNC_DEPTH = 3;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic pwrDown;
        logic sqDis;
        logic [LANES-1:0] rxDis;
        logic [LANES-1:0] txDis;
    } ctrl_s;

    typedef struct packed {
        logic ready;
        logic [LANES-1:0] other;
        logic [LANES-1:0] txFlt;
        logic [LANES-1:0] rxLos;
    } flags_s;

    typedef struct packed {
        logic [LANES-1:0] other;
        logic [LANES-1:0] txLost;
        logic [LANES-1:0] txFlt;
        logic [LANES-1:0] rxLos;
    } pins_s;

    typedef struct packed {
        logic [LANES-1:0] rxOn;
        logic [LANES-1:0] txOn;
    } lane_out_s;

    typedef enum logic [2:0] {
        ST_INIT = 3'b001,
        ST_RUN = 3'b010,
        ST_LOWPWR = 3'b100
    } mode_e;

endpackage : mgmt_pkg

`default_nettype wire

// *** sim/pin_source.sv ***
`default_nettype none

// ========
// Far-side line conditions, stepped on the link clock
module pin_source (
    input wire logic linkClk,
    input wire logic [15:0] want,
    output var mgmt_pkg::pins_s modPins = '0
);
    timeunit 1ns;
    timeprecision 100ps;
    import mgmt_pkg::*;

    // Levels change only on the link clock, eight ref_clk periods long and 7 ns after a falling ref_clk edge, so the sync path is exercised
    always @(posedge linkClk) begin
        modPins <= pins_s'(want);
    end
endmodule : pin_source

`default_nettype wire

// *** sim/mgmt_status_timing_monitor.sv ***
`default_nettype none

// ========
// Port checker
module mgmt_status_timing_mon (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire mgmt_pkg::pins_s modPins,
    input wire logic module_reset_n,
    input wire mgmt_pkg::lane_out_s laneOut,
    input wire logic lowPower,
    input wire logic intN,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 100ps;
    import mgmt_pkg::*;

    // Bus decode
    wire logic taken = hsel && hready && htrans[1];
    wire logic wrCtrl = taken && hwrite && (haddr[7:0] == OFF_CTRL);
    wire logic rdFlags = taken && !hwrite && (haddr[7:0] == OFF_FLAGS);
    logic wrPhase_ff;
    logic sqDis_ff;
    logic [3:0] quiet_ff;
    // Quiet counts cycles since the host or the reset pin last acted; saturates so it never wraps
    wire logic [3:0] nxt_quiet = (taken || !module_reset_n) ? 4'h0 : quiet_ff + {3'h0, quiet_ff != 4'hF};
    wire logic nxt_sqDis = module_reset_n && (wrPhase_ff ? hwdata[CTL_SQDIS_BIT] : sqDis_ff);

    // Shadow of the squelch-disable bit and the quiet counter
    always_ff @(posedge ref_clk) begin
        wrPhase_ff <= !rst && wrCtrl;
        sqDis_ff <= !rst && nxt_sqDis;
        quiet_ff <= rst ? 4'h0 : nxt_quiet;
    end

    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    // ========
    // Sequences and properties
    sequence s_calm;
        $stable(modPins) [*8];
    endsequence
    sequence s_lostRx;
        (modPins.rxLos[0] && !sqDis_ff) [*8];
    endsequence

    property p_intPin;
        intN == !irq;
    endproperty
    property p_release;
        $fell(irq) |-> quiet_ff < 4'h6;
    endproperty
    property p_readClear;
        s_calm ##0 rdFlags |-> ##[1:3] !irq;
    endproperty
    property p_rxSquelch;
        s_lostRx |-> !laneOut.rxOn[0];
    endproperty
    property p_txOff;
        wrPhase_ff && hwdata[CTL_TXDIS_LSB] |-> ##[1:4] !laneOut.txOn[0];
    endproperty
    property p_pdEnter;
        wrPhase_ff && module_reset_n && hwdata[CTL_PDOWN_BIT] |-> ##[1:4] lowPower;
    endproperty
    property p_pdLeave;
        wrPhase_ff && !hwdata[CTL_PDOWN_BIT] |-> ##[1:4] !lowPower;
    endproperty
    property p_quietLanes;
        lowPower |-> laneOut == '0;
    endproperty

    a_intPin: assert property (p_intPin)
        else $error("interrupt pin not inverse of irq");
    a_release: assert property (p_release)
        else $error("interrupt dropped with no host action");
    a_readClear: assert property (p_readClear)
        else $error("interrupt held after flag read");
    a_rxSquelch: assert property (p_rxSquelch)
        else $error("receive output not squelched");
    a_txOff: assert property (p_txOff)
        else $error("transmit lane not disabled");
    a_pdEnter: assert property (p_pdEnter)
        else $error("low power not entered");
    a_pdLeave: assert property (p_pdLeave)
        else $error("low power not left");
    a_quietLanes: assert property (p_quietLanes)
        else $error("lanes active in low power");
endmodule : mgmt_status_timing_mon

bind mgmt_status_timing mgmt_status_timing_mon i_mon (
    .ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .modPins(modPins),
    .module_reset_n(module_reset_n), .laneOut(laneOut), .lowPower(lowPower),
    .intN(intN), .irq(irq)
);

`default_nettype wire

// *** sim/tb_top.sv ***
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import mgmt_pkg::*;

    // Short millisecond keeps the run small; the MS_CYC bounds below scale with it
    localparam int US_MS = 2;
    localparam int MS_CYC = US_MS * CYC_PER_US;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic linkClk = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [2:0] hsize = 3'h0;
    logic module_reset_n = 1'b1;
    logic [15:0] pinWant = 16'h0000;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    pins_s pins;
    lane_out_s laneOut;
    logic lowPower;
    logic intN;
    logic irq;
    int failures = 0;
    int compares = 0;
    int cyc = 0;

    // ========
    // Clocks and instances
    always #20 ref_clk = ~ref_clk;
    initial begin
        #7;
        forever #160 linkClk = ~linkClk;
    end

    mgmt_status_timing #(.US_PER_MS(US_MS), .INIT_MS(2)) i_dut (
        .ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .modPins(pins),
        .module_reset_n(module_reset_n), .laneOut(laneOut), .lowPower(lowPower),
        .intN(intN), .irq(irq)
    );
    pin_source i_pins (.linkClk(linkClk), .want(pinWant), .modPins(pins));

    // ========
    // Tasks
    task automatic test_done;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One edge, then on until the slave shows ready; only the hang guard ends a wait
    task automatic rdyEdge;
        do begin
            @(posedge ref_clk);
        end while (hreadyout !== 1'b1);
    endtask : rdyEdge

    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= 2'b10;
        hwrite <= wr;
        hsize <= 3'h2;
        rdyEdge();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        rdyEdge();
        rd = hrdata;
        // Every answer must carry the OKAY response
        chk({31'h0, hresp}, 32'h0000_0000);
    endtask : ahb

    task automatic regWr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        ahb(1'b1, a, d, x);
    endtask : regWr

    task automatic regChk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] x;
        ahb(1'b0, a, 32'h0000_0000, x);
        chk(x, e);
    endtask : regChk

    // Sampled at the falling edge so the registered irq has settled
    task automatic waitIrq(input logic e, input int lim);
        int n;
        n = 0;
        @(negedge ref_clk);
        while (irq !== e && n < lim) begin
            @(negedge ref_clk);
            n++;
        end
        // The active-low pin must follow the level in the same cycle
        chk({30'h0, intN, irq}, {30'h0, ~e, e});
        @(posedge ref_clk);
    endtask : waitIrq

    task automatic laneRow(input logic [31:0] c, input logic [15:0] p, input logic [8:0] e);
        regWr(OFF_CTRL, c);
        pinWant <= p;
        repeat (40) @(posedge ref_clk);
        @(negedge ref_clk);
        chk({23'h0, lowPower, laneOut}, {23'h0, e});
        @(posedge ref_clk);
    endtask : laneRow

    // Hang guard
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 30000) begin
            failures++;
            test_done();
        end
    end

    // ========
    // Main sequence
    initial begin
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        regChk(OFF_STATUS, 32'h0001_0000);
        regChk(OFF_FLAGS, 32'h0000_0000);
        waitIrq(1'b1, 2000 * MS_CYC);
        regChk(OFF_FLAGS, 32'h0000_1000);
        waitIrq(1'b0, 500 * CYC_PER_US);
        regChk(OFF_STATUS, 32'h0000_0000);
        $display("init test done");
        regWr(OFF_MASK, 32'hFFFF_FFFF);
        regChk(OFF_MASK, 32'h0000_1FFF);
        regWr(8'h10, 32'hFFFF_FFFF);
        regChk(8'h10, 32'h0000_0000);
        regWr(OFF_MASK, 32'h0000_0000);
        $display("register test done");
        // Status shows the live level: rx loss in [3:0], tx fault in [11:8], others not at all
        for (int i = 0; i < 3; i++) begin
            pinWant <= 16'h0001 << (i == 2 ? 12 : 4 * i);
            waitIrq(1'b1, 200 * MS_CYC);
            regChk(OFF_STATUS, i == 2 ? 32'h0000_0000 : 32'h0000_0001 << (8 * i));
            regChk(OFF_FLAGS, 32'h0000_0001 << (4 * i));
            waitIrq(1'b0, 500 * CYC_PER_US);
            pinWant <= 16'h0000;
            repeat (20) @(posedge ref_clk);
        end
        $display("flag test done");
        // Two flags pending: clearing one must not release the pin
        pinWant <= 16'h0011;
        waitIrq(1'b1, 100 * MS_CYC);
        regWr(OFF_MASK, 32'h0000_0011);
        waitIrq(1'b0, 100 * MS_CYC);
        regWr(OFF_MASK, 32'h0000_0000);
        waitIrq(1'b1, 100 * MS_CYC);
        regWr(OFF_FLAGS, 32'h0000_0001);
        repeat (20) @(posedge ref_clk);
        waitIrq(1'b1, 0);
        regWr(OFF_FLAGS, 32'h0000_0010);
        waitIrq(1'b0, 500 * CYC_PER_US);
        pinWant <= 16'h0000;
        $display("mask test done");
        laneRow(32'h0000_0000, 16'h0000, 9'h0FF);
        laneRow(32'h0000_0001, 16'h0000, 9'h0FE);
        laneRow(32'h0000_00F0, 16'h0000, 9'h00F);
        laneRow(32'h0000_0000, 16'h0000, 9'h0FF);
        laneRow(32'h0000_0200, 16'h0000, 9'h100);
        regChk(OFF_STATUS, 32'h0000_1000);
        laneRow(32'h0000_0000, 16'h0000, 9'h0FF);
        laneRow(32'h0000_0000, 16'h0100, 9'h0FE);
        regChk(OFF_STATUS, 32'h0000_0010);
        laneRow(32'h0000_0000, 16'h0001, 9'h0EF);
        regChk(OFF_STATUS, 32'h0000_0001);
        laneRow(32'h0000_0100, 16'h0001, 9'h0FF);
        laneRow(32'h0000_0100, 16'h0100, 9'h0FF);
        laneRow(32'h0000_0000, 16'h0000, 9'h0FF);
        regChk(OFF_FLAGS, 32'h0000_0001);
        waitIrq(1'b0, 500 * CYC_PER_US);
        $display("lane test done");
        regWr(OFF_MASK, 32'h0000_000F);
        module_reset_n <= 1'b0;
        repeat (20) @(posedge ref_clk);
        regChk(OFF_MASK, 32'h0000_0000);
        regChk(OFF_STATUS, 32'h0001_0000);
        module_reset_n <= 1'b1;
        waitIrq(1'b1, 2000 * MS_CYC);
        regChk(OFF_FLAGS, 32'h0000_1000);
        $display("module reset test done");
        test_done();
    end
endmodule : tb_top

`default_nettype wire
